// *** src/sdcio_pkg.sv ***
package sdcio_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned CLR_HOLD_MS   = 50;
    localparam int unsigned PWRUP_MAX_MS  = 1500;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    // Least time: one cycle beyond the hold so that "longer than" is met.
    localparam int unsigned CLR_HOLD_CYC  = CLR_HOLD_MS * CYC_PER_MS + 1;
    // Longest time: rounded down, taken a little early to stay inside the bound.
    localparam int unsigned PWRUP_CYC     = PWRUP_MAX_MS * CYC_PER_MS - 1;
    localparam int unsigned CNT_W         = 24;

    // ****************************************************************
    // Control modes
    // ****************************************************************
    typedef enum logic [2:0] {
        SDCIO_MODE_POS    = 3'h0,
        SDCIO_MODE_SPD    = 3'h1,
        SDCIO_MODE_TRQ    = 3'h2,
        SDCIO_MODE_POSSPD = 3'h3,
        SDCIO_MODE_SPDTRQ = 3'h4,
        SDCIO_MODE_TRQPOS = 3'h5
    } sdcio_mode_t;

    // ****************************************************************
    // Drive states
    // ****************************************************************
    typedef enum logic [2:0] {
        SDCIO_ST_BOOT  = 3'h0,
        SDCIO_ST_IDLE  = 3'h1,
        SDCIO_ST_ON    = 3'h2,
        SDCIO_ST_FAULT = 3'h3,
        SDCIO_ST_ESTOP = 3'h4
    } sdcio_state_t;

    // Motion command encoding.
    localparam logic [1:0] MOVE_STOP = 2'h0;
    localparam logic [1:0] MOVE_CW   = 2'h1;
    localparam logic [1:0] MOVE_CCW  = 2'h2;

endpackage

// *** src/sdcio_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for a bus of pin inputs.
module sdcio_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

// *** src/sdcio_top.sv ***
`timescale 1ns/1ps
module sdcio_top #(
    parameter int unsigned DROOP_W   = 16,
    parameter int unsigned HOLD_CYC  = sdcio_pkg::CLR_HOLD_CYC,
    parameter int unsigned PWRUP_CYC = sdcio_pkg::PWRUP_CYC
) (
    // Clock and reset
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst,
    // Connector inputs, asynchronous
    input  wire logic               i_servo_enable_input,
    input  wire logic               i_alarm_clear_input,
    input  wire logic               i_fwd_start_input,
    input  wire logic               i_rev_start_input,
    input  wire logic               i_fwd_limit_input,
    input  wire logic               i_rev_limit_input,
    input  wire logic               i_forced_stop_input,
    // Internal amplifier status, same clock
    input  wire logic               i_power_good,
    input  wire logic               i_protect_trip,
    input  wire logic [2:0]         i_ctrl_mode,
    input  wire logic               i_mode_select,
    input  wire logic [DROOP_W-1:0] i_droop_count,
    input  wire logic [DROOP_W-1:0] i_inpos_range,
    // Drive outputs
    output logic                    o_main_power_on,
    output logic                    o_dyn_brake,
    output logic [1:0]              o_move_cmd,
    output logic                    o_decel_stop,
    output logic [2:0]              o_active_mode,
    // Connector outputs
    output logic                    o_fault_free_output,
    output logic                    o_ready_output,
    output logic                    o_in_position_output
);

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    logic [6:0] pin_s;
    logic       srv_s, clr_s, fst_s, rst_s, lfw_s, lrv_s, fstop_s;

    sdcio_sync #(.W(7)) sdcio_sync_inst (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   ({i_servo_enable_input, i_alarm_clear_input, i_fwd_start_input,
                     i_rev_start_input, i_fwd_limit_input, i_rev_limit_input,
                     i_forced_stop_input}),
        .o_sync    (pin_s)
    );

    assign {srv_s, clr_s, fst_s, rst_s, lfw_s, lrv_s, fstop_s} = pin_s;

    // ****************************************************************
    // Alarm clear hold timer and power-up timer
    // ****************************************************************
    logic [sdcio_pkg::CNT_W-1:0] hold_q, hold_d;
    logic [sdcio_pkg::CNT_W-1:0] pwr_q, pwr_d;
    logic                        clr_ok;
    logic                        boot_done;

    localparam int unsigned          CW       = sdcio_pkg::CNT_W;
    localparam logic [CW-1:0]        HOLD_LIM = CW'(HOLD_CYC);
    localparam logic [CW-1:0]        PWR_LIM  = CW'(PWRUP_CYC);

    always_comb begin
        hold_d = '0;
        if (clr_s) begin
            // Saturate so a very long press still reads as one clear.
            hold_d = (hold_q == HOLD_LIM) ? hold_q : hold_q + 1'b1;
        end
        pwr_d = pwr_q;
        if (!i_power_good) begin
            pwr_d = '0;
        end else if (pwr_q != PWR_LIM) begin
            pwr_d = pwr_q + 1'b1;
        end
    end

    assign clr_ok    = (hold_q == HOLD_LIM);
    assign boot_done = (pwr_q == PWR_LIM);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            hold_q <= '0;
            pwr_q  <= '0;
        end else begin
            hold_q <= hold_d;
            pwr_q  <= pwr_d;
        end
    end

    // ****************************************************************
    // Drive state machine
    // ****************************************************************
    sdcio_pkg::sdcio_state_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (!i_power_good) begin
            st_d = sdcio_pkg::SDCIO_ST_BOOT;
        end else begin
            unique case (st_q)
                sdcio_pkg::SDCIO_ST_BOOT: begin
                    // A trip at the end of power-up must not flash the fault-free output.
                    if (boot_done && !i_protect_trip) begin
                        st_d = sdcio_pkg::SDCIO_ST_IDLE;
                    end else if (boot_done) begin
                        st_d = sdcio_pkg::SDCIO_ST_FAULT;
                    end
                end
                sdcio_pkg::SDCIO_ST_IDLE,
                sdcio_pkg::SDCIO_ST_ON: begin
                    if (i_protect_trip) begin
                        st_d = sdcio_pkg::SDCIO_ST_FAULT;
                    end else if (!fstop_s) begin
                        st_d = sdcio_pkg::SDCIO_ST_ESTOP;
                    end else if (srv_s) begin
                        st_d = sdcio_pkg::SDCIO_ST_ON;
                    end else begin
                        st_d = sdcio_pkg::SDCIO_ST_IDLE;
                    end
                end
                sdcio_pkg::SDCIO_ST_FAULT: begin
                    if (clr_ok && !i_protect_trip) begin
                        st_d = sdcio_pkg::SDCIO_ST_IDLE;
                    end
                end
                sdcio_pkg::SDCIO_ST_ESTOP: begin
                    if (i_protect_trip) begin
                        st_d = sdcio_pkg::SDCIO_ST_FAULT;
                    end else if (fstop_s) begin
                        st_d = sdcio_pkg::SDCIO_ST_IDLE;
                    end
                end
                default: begin
                    st_d = sdcio_pkg::SDCIO_ST_BOOT;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_q <= sdcio_pkg::SDCIO_ST_BOOT;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Motion command and outputs
    // ****************************************************************
    logic [1:0] move_q, move_d;
    logic       decel_q, decel_d;
    logic       main_q, main_d;
    logic       brake_q, brake_d;
    logic       ffree_q, ffree_d;
    logic       rdy_q, rdy_d;
    logic       inpos_q, inpos_d;
    logic [2:0] mode_q, mode_d;

    always_comb begin
        move_d  = sdcio_pkg::MOVE_STOP;
        decel_d = 1'b0;
        if (st_d == sdcio_pkg::SDCIO_ST_ON && fstop_s) begin
            if (fst_s && !rst_s && lfw_s) begin
                move_d = sdcio_pkg::MOVE_CW;
            end else if (rst_s && !fst_s && lrv_s) begin
                move_d = sdcio_pkg::MOVE_CCW;
            end else if (fst_s == rst_s) begin
                decel_d = 1'b1;
            end else begin
                // Start toward a tripped limit is refused with a stop.
                decel_d = 1'b1;
            end
        end
        main_d  = (st_d == sdcio_pkg::SDCIO_ST_ON);
        brake_d = (st_d == sdcio_pkg::SDCIO_ST_ESTOP);
        ffree_d = (st_d != sdcio_pkg::SDCIO_ST_BOOT) &&
                  (st_d != sdcio_pkg::SDCIO_ST_FAULT);
        rdy_d   = main_d;
        inpos_d = main_d && (i_droop_count <= i_inpos_range);
        // Changeover modes pick one of the pair by the select input.
        unique case (i_ctrl_mode)
            sdcio_pkg::SDCIO_MODE_POSSPD: mode_d = i_mode_select ? sdcio_pkg::SDCIO_MODE_SPD
                                                                 : sdcio_pkg::SDCIO_MODE_POS;
            sdcio_pkg::SDCIO_MODE_SPDTRQ: mode_d = i_mode_select ? sdcio_pkg::SDCIO_MODE_TRQ
                                                                 : sdcio_pkg::SDCIO_MODE_SPD;
            sdcio_pkg::SDCIO_MODE_TRQPOS: mode_d = i_mode_select ? sdcio_pkg::SDCIO_MODE_POS
                                                                 : sdcio_pkg::SDCIO_MODE_TRQ;
            sdcio_pkg::SDCIO_MODE_POS,
            sdcio_pkg::SDCIO_MODE_SPD,
            sdcio_pkg::SDCIO_MODE_TRQ:    mode_d = i_ctrl_mode;
            default:                      mode_d = mode_q;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            move_q  <= sdcio_pkg::MOVE_STOP;
            decel_q <= 1'b0;
            main_q  <= 1'b0;
            brake_q <= 1'b0;
            ffree_q <= 1'b0;
            rdy_q   <= 1'b0;
            inpos_q <= 1'b0;
            mode_q  <= sdcio_pkg::SDCIO_MODE_POS;
        end else begin
            move_q  <= move_d;
            decel_q <= decel_d;
            main_q  <= main_d;
            brake_q <= brake_d;
            ffree_q <= ffree_d;
            rdy_q   <= rdy_d;
            inpos_q <= inpos_d;
            mode_q  <= mode_d;
        end
    end

    assign o_move_cmd           = move_q;
    assign o_decel_stop         = decel_q;
    assign o_main_power_on      = main_q;
    assign o_dyn_brake          = brake_q;
    assign o_fault_free_output  = ffree_q;
    assign o_ready_output       = rdy_q;
    assign o_in_position_output = inpos_q;
    assign o_active_mode        = mode_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    chk_brake_cuts_power: assert property (o_dyn_brake |-> !o_main_power_on)
        else $error("Brake applied while main circuit on.");
    chk_estop_blocks_move: assert property (!fstop_s |=> o_move_cmd == sdcio_pkg::MOVE_STOP)
        else $error("Motion during forced stop.");
    chk_fwd_limit_block: assert property (!lfw_s |=> o_move_cmd != sdcio_pkg::MOVE_CW)
        else $error("Clockwise past forward limit.");
    chk_rev_limit_block: assert property (!lrv_s |=> o_move_cmd != sdcio_pkg::MOVE_CCW)
        else $error("Counter-clockwise past reverse limit.");
    chk_both_starts_stop: assert property (
        (st_d == sdcio_pkg::SDCIO_ST_ON && fstop_s && fst_s == rst_s) |=> o_decel_stop)
        else $error("Equal starts did not decelerate.");
    chk_ready_main: assert property (o_ready_output == o_main_power_on)
        else $error("Ready disagrees with servo-on.");
    sequence trip_seen;
        i_protect_trip && i_power_good;
    endsequence

    sequence fault_unheld;
        st_q == sdcio_pkg::SDCIO_ST_FAULT && !clr_ok && i_power_good;
    endsequence

    chk_trip_drops_ok: assert property (trip_seen |=> !o_fault_free_output)
        else $error("Fault-free output held through trip.");
    chk_power_drops_ok: assert property (!i_power_good |=> !o_fault_free_output)
        else $error("Fault-free output held without power.");
    chk_clear_needs_hold: assert property (
        fault_unheld |=> st_q == sdcio_pkg::SDCIO_ST_FAULT)
        else $error("Alarm cleared without sustained hold.");
    chk_inpos_range: assert property (
        o_in_position_output |-> $past(i_droop_count) <= $past(i_inpos_range))
        else $error("In-position outside range.");

endmodule

// *** tb/sdcio_ctrl_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Machine controller model
// ****************************************************************
// Pin levels reach the drive one edge after they are requested.
module sdcio_ctrl_model #(
    parameter int unsigned HOLD_CYC = 10
) (
    input  wire logic       i_sys_clk,
    input  wire logic [5:0] i_pins_req,
    input  wire logic       i_clear_go,
    input  wire logic       i_clear_short,
    output logic      [5:0] o_pins,
    output logic            o_clear
);
    int unsigned cnt_q = 0;
    initial o_pins = 6'h00;
    initial o_clear = 1'b0;
    always @(posedge i_sys_clk) begin
        o_pins <= i_pins_req;
        // The short pulse exists only to show that the alarm stays latched.
        if (i_clear_go) begin
            cnt_q <= i_clear_short ? HOLD_CYC - 3 : HOLD_CYC + 2;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
        o_clear <= i_clear_go || cnt_q > 1;
    end
endmodule

// *** tb/sdcio_top_tb.sv ***
`timescale 1ns/1ps
module sdcio_top_tb;
    localparam int unsigned HOLD = 10;
    localparam int unsigned PWR  = 20;
    // Pin request bits: servo, fwd, rev, fwd limit, rev limit, forced stop.
    logic        i_sys_clk    = 1'b0;
    logic        i_rst        = 1'b1;
    logic [5:0]  pins_req     = 6'h07;
    logic        clear_go     = 1'b0;
    logic        clear_short  = 1'b0;
    logic        power_good   = 1'b0;
    logic        protect_trip = 1'b0;
    logic [2:0]  ctrl_mode    = 3'h0;
    logic        mode_select  = 1'b0;
    logic [15:0] droop        = 16'h0000;
    logic [15:0] range        = 16'h0010;
    logic [5:0]  pins;
    logic        alarm_clear;
    logic        main_on;
    logic        brake;
    logic        decel;
    logic        fault_free;
    logic        ready;
    logic        inpos;
    logic [1:0]  move;
    logic [2:0]  act_mode;
    int          errors       = 0;
    int          checked      = 0;

    always #50 i_sys_clk = ~i_sys_clk;

    sdcio_ctrl_model #(.HOLD_CYC(HOLD)) sdcio_ctrl_model_inst (
        .i_sys_clk(i_sys_clk), .i_pins_req(pins_req), .i_clear_go(clear_go),
        .i_clear_short(clear_short), .o_pins(pins), .o_clear(alarm_clear));

    sdcio_top #(.DROOP_W(16), .HOLD_CYC(HOLD), .PWRUP_CYC(PWR)) sdcio_top_inst (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_servo_enable_input(pins[5]), .i_alarm_clear_input(alarm_clear),
        .i_fwd_start_input(pins[4]), .i_rev_start_input(pins[3]),
        .i_fwd_limit_input(pins[2]), .i_rev_limit_input(pins[1]),
        .i_forced_stop_input(pins[0]), .i_power_good(power_good),
        .i_protect_trip(protect_trip), .i_ctrl_mode(ctrl_mode),
        .i_mode_select(mode_select), .i_droop_count(droop), .i_inpos_range(range),
        .o_main_power_on(main_on), .o_dyn_brake(brake), .o_move_cmd(move),
        .o_decel_stop(decel), .o_active_mode(act_mode),
        .o_fault_free_output(fault_free), .o_ready_output(ready),
        .o_in_position_output(inpos));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic check(input logic [2:0] got, input logic [2:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic set_pins(input logic [5:0] v);
        @(posedge i_sys_clk);
        pins_req <= v;
        cyc(6);
    endtask

    task automatic summarize();
        $display("Checks %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_powerup();
        @(posedge i_sys_clk);
        power_good <= 1'b1;
        cyc(PWR / 2);
        check(fault_free, 1'b0, "fault-free early");
        cyc(PWR / 2 + 6);
        check(fault_free, 1'b1, "fault-free late");
        check(ready, 1'b0, "ready before servo");
        set_pins(6'h27);
        check(main_on, 1'b1, "main power");
        check(ready, 1'b1, "ready");
    endtask

    task automatic t_starts();
        logic [5:0] req [8] = '{6'h37, 6'h2F, 6'h3F, 6'h27, 6'h33, 6'h2B, 6'h2D, 6'h35};
        logic [1:0] mv [8]  = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1};
        logic       dc [8]  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 8; i++) begin
            set_pins(req[i]);
            check(move, mv[i], "move");
            check(decel, dc[i], "decel");
        end
    endtask

    task automatic t_inpos();
        @(posedge i_sys_clk);
        droop <= 16'h0010;
        cyc(3);
        check(inpos, 1'b1, "in position at edge");
        @(posedge i_sys_clk);
        droop <= 16'h0011;
        cyc(3);
        check(inpos, 1'b0, "in position beyond");
    endtask

    task automatic t_modes();
        logic [2:0] md [10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6};
        logic       sl [10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [2:0] ex [10] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h0, 3'h0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_sys_clk);
            ctrl_mode   <= md[i];
            mode_select <= sl[i];
            cyc(3);
            check(act_mode, ex[i], "mode");
        end
    endtask

    task automatic t_estop();
        set_pins(6'h36);
        check(brake, 1'b1, "brake");
        check(main_on, 1'b0, "main off in stop");
        check(move, 2'h0, "move in stop");
        set_pins(6'h37);
        check(brake, 1'b0, "brake released");
        set_pins(6'h27);
    endtask

    task automatic t_fault();
        @(posedge i_sys_clk);
        protect_trip <= 1'b1;
        cyc(3);
        check(fault_free, 1'b0, "trip");
        check(main_on, 1'b0, "main off on trip");
        @(posedge i_sys_clk);
        protect_trip <= 1'b0;
        clear_go     <= 1'b1;
        clear_short  <= 1'b1;
        @(posedge i_sys_clk);
        clear_go <= 1'b0;
        cyc(HOLD + 8);
        check(fault_free, 1'b0, "short clear");
        @(posedge i_sys_clk);
        clear_go    <= 1'b1;
        clear_short <= 1'b0;
        @(posedge i_sys_clk);
        clear_go <= 1'b0;
        cyc(HOLD + 8);
        check(fault_free, 1'b1, "long clear");
        @(posedge i_sys_clk);
        power_good <= 1'b0;
        cyc(3);
        check(fault_free, 1'b0, "power loss");
    endtask

    initial begin
        cyc(20000);
        errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        cyc(3);
        t_powerup();
        t_starts();
        t_inpos();
        t_modes();
        t_estop();
        t_fault();
        summarize();
    end
endmodule
